// ==== bench/frps_chk_sva.sv ====
`timescale 1ns/100ps
module frps_chk (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// Host port
	input wire logic [15:0] HOST_ADDR,
	input wire logic [7:0] HOST_WDATA,
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	input wire logic [7:0] HOST_RDATA,
	// Status sources
	input wire logic POLLED_MODE,
	input wire logic EXEC_ACTIVE,
	input wire logic XFER_READY,
	input wire logic XFER_TO_HOST,
	input wire logic DRIVE_A_SEEKING,
	input wire logic DRIVE_B_SEEKING,
	// Controls
	input wire logic CTRL_RESET,
	input wire logic LOW_POWER,
	input wire logic [7:0] RATE_SELECT_SHADOW
);
	import frps_pkg::*;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	wire st_rd = HOST_RD && HOST_ADDR == FRPS_ADDR_STATUS;
	wire st_wr = HOST_WR && HOST_ADDR == FRPS_ADDR_STATUS;
	wire dt_acc = (HOST_RD || HOST_WR) && HOST_ADDR == FRPS_ADDR_DATA;
	////////////////////////////////////////////////////////////////////////////////
	AST_SHADOW: assert property (st_wr |=> RATE_SELECT_SHADOW == $past(HOST_WDATA))
		else $error("shadow differs from last write");
	AST_SWRST: assert property (st_wr && HOST_WDATA[7] |=> CTRL_RESET [*2])
		else $error("soft reset too short");
	AST_LP_SET: assert property (st_wr && HOST_WDATA[7:6] == 2'b01 |=> LOW_POWER)
		else $error("low power not entered");
	AST_LP_EXIT: assert property (st_rd || dt_acc || (st_wr && !HOST_WDATA[6]) |=> !LOW_POWER)
		else $error("low power not left");
	AST_RSVD: assert property (st_rd |=> HOST_RDATA[3:2] == 2'b00)
		else $error("reserved status bits set");
	AST_RQM: assert property (st_rd && (!XFER_READY || CTRL_RESET) |=> !HOST_RDATA[7])
		else $error("request shown while not ready");
	AST_DIR: assert property (st_rd && XFER_READY && !CTRL_RESET |=>
		HOST_RDATA[7:6] == {1'b1, $past(XFER_TO_HOST)})
		else $error("direction bit wrong");
	AST_SEEK: assert property (st_rd |=>
		HOST_RDATA[1:0] == {$past(DRIVE_B_SEEKING), $past(DRIVE_A_SEEKING)})
		else $error("seek bits wrong");
	AST_POLL: assert property (st_rd |=>
		HOST_RDATA[5] == ($past(POLLED_MODE) && $past(EXEC_ACTIVE)))
		else $error("polled bit wrong");
	AST_IDLE: assert property (!st_rd |=> HOST_RDATA == 8'h00)
		else $error("read data outside a status read");
	C_SWRST: cover property (st_wr && HOST_WDATA[7]);
	C_LP: cover property (st_wr && HOST_WDATA[7:6] == 2'b01);
	C_RQM: cover property (st_rd && XFER_READY && !CTRL_RESET);
endmodule : frps_chk
bind frps_top frps_chk u_chk (.CORE_CLK, .SYS_RST, .HOST_ADDR, .HOST_WDATA, .HOST_WR, .HOST_RD,
	.HOST_RDATA, .POLLED_MODE, .EXEC_ACTIVE, .XFER_READY, .XFER_TO_HOST, .DRIVE_A_SEEKING,
	.DRIVE_B_SEEKING, .CTRL_RESET, .LOW_POWER, .RATE_SELECT_SHADOW);

// ==== bench/frps_eng_model.sv ====
`timescale 1ns/100ps
module frps_eng_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command launch
	input wire logic go,
	input wire logic kind,
	input wire logic drv,
	input wire logic [7:0] lat,
	// Status to the block
	output logic cmd_acc,
	output logic res_done,
	output logic no_res_done,
	output logic exec,
	output logic seek_a,
	output logic seek_b
);
	logic kind_r, drv_r;
	logic [7:0] cnt_r;
	// Latency comes per command, so one model serves prompt and slow cases
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{cmd_acc, res_done, no_res_done, kind_r, drv_r} <= 5'h00;
			cnt_r <= 8'h00;
		end else begin
			cmd_acc <= go;
			no_res_done <= cmd_acc && !kind_r;
			res_done <= kind_r && cnt_r == 8'h01;
			if (go) begin
				kind_r <= kind;
				drv_r <= drv;
				cnt_r <= lat;
			end else if (cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end
	assign exec = kind_r && cnt_r != 8'h00;
	// Seek outlives the command bytes, as a real drive does
	assign seek_a = !kind_r && !drv_r && cnt_r != 8'h00;
	assign seek_b = !kind_r && drv_r && cnt_r != 8'h00;
endmodule : frps_eng_model

// ==== bench/test_floppy_rate_write_delay_code_status.sv ====
`timescale 1ns/100ps
module test_floppy_rate_write_delay_code_status;
	import frps_pkg::*;
	logic clk, rst, wr, rd, rt_hi, rt_lo, ty_hi, ty_lo, wdi, pol, rdy, toh, go, kind, drv, trk_ld;
	logic [15:0] addr;
	logic [7:0] wdat, lat, rdat, shadow, trk;
	logic cacc, rdone, lbnr, exec, sa, sb, wdo, crst, lpw, fmok, dens, p0, p1;
	frps_rate_t rate;
	int error_cnt, n_checks, cyc;
	// Current track held at 0, so a start track above it must suppress the delay
	frps_top uut (.CORE_CLK(clk), .SYS_RST(rst), .HOST_ADDR(addr), .HOST_WDATA(wdat),
		.HOST_WR(wr), .HOST_RD(rd), .HOST_RDATA(rdat), .CMD_ACCEPTED(cacc),
		.RESULT_DONE(rdone), .LAST_BYTE_NO_RESULT(lbnr), .EXEC_ACTIVE(exec),
		.POLLED_MODE(pol), .XFER_READY(rdy), .XFER_TO_HOST(toh), .DRIVE_A_SEEKING(sa),
		.DRIVE_B_SEEKING(sb), .DRIVE_RATE_TABLE_HI(rt_hi), .DRIVE_RATE_TABLE_LO(rt_lo),
		.DRIVE_TYPE_HI(ty_hi), .DRIVE_TYPE_LO(ty_lo), .WRITE_DELAY_CODE_START_TRACK(trk),
		.WRITE_DELAY_CODE_TRACK_LOAD(trk_ld), .CURRENT_TRACK(8'h00), .WRITE_DATA_IN(wdi),
		.WRITE_DATA_OUT(wdo), .CTRL_RESET(crst), .LOW_POWER(lpw), .RATE_SELECT_SHADOW(shadow),
		.DATA_RATE(rate), .FM_HALF_RATE_OK(fmok), .DENSITY_SELECT(dens),
		.DRIVE_DENSITY_PIN0(p0), .DRIVE_DENSITY_PIN1(p1));
	frps_eng_model eng (.clk(clk), .rst(rst), .go(go), .kind(kind), .drv(drv), .lat(lat),
		.cmd_acc(cacc), .res_done(rdone), .no_res_done(lbnr), .exec(exec), .seek_a(sa),
		.seek_b(sb));
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : pause
	task automatic hw(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : hw
	task automatic hr(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdat, e);
	endtask : hr
	task automatic start(input logic k, input logic [7:0] l, input logic d);
		@(posedge clk);
		go <= 1'b1;
		kind <= k;
		lat <= l;
		drv <= d;
		@(posedge clk);
		go <= 1'b0;
	endtask : start
	function automatic frps_rate_t exp_rate(input int drt, input logic [1:0] c);
		case (c)
			2'h3: return FRPS_R1M;
			2'h0: return FRPS_R500K;
			2'h2: return FRPS_R250K;
			default: return drt == 1 ? FRPS_R500K : (drt == 2 ? FRPS_R2M : FRPS_R300K);
		endcase
	endfunction : exp_rate
	function automatic int exp_tap(input logic hi, input int c);
		if (c == 7) return 0;
		if (c == 0) return hi ? 1 : 2;
		return hi ? (c > 4 ? 2 : 1) : (c < 3 ? 1 : c - 1);
	endfunction : exp_tap
	// Pulse the write data and count cycles until it leaves delayed
	task automatic pc(input logic hi, input logic [2:0] c, input logic early);
		int n;
		@(posedge clk);
		rt_hi <= hi;
		rt_lo <= 1'b0;
		hw(FRPS_ADDR_STATUS, {3'h0, c, hi ? 2'h1 : 2'h2});
		pause(3);
		@(posedge clk);
		wdi <= 1'b1;
		for (n = 1; n <= 10; n++) begin
			@(posedge clk);
			wdi <= 1'b0;
			#1;
			if (wdo === 1'b1) break;
		end
		chk(n[7:0], 8'(1 + (early ? 0 : exp_tap(hi, c))));
	endtask : pc
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		{rst, wr, rd, rt_hi, rt_lo, ty_hi, ty_lo, wdi, pol, rdy, toh, go, kind, drv} = 14'h2000;
		{addr, wdat, lat} = 32'h0;
		{trk_ld, trk} = 9'h000;
		error_cnt = 0;
		n_checks = 0;
		cyc = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(shadow, 8'h02);
		chk({5'h0, rate}, {5'h0, FRPS_R250K});
		chk({6'h0, crst, lpw}, 8'h02);
		hw(FRPS_ADDR_DOR, 8'h04);
		pause(2);
		chk({7'h0, crst}, 8'h00);
		for (int t = 0; t < 4; t++) for (int c = 0; c < 4; c++) begin
			logic d;
			frps_rate_t er;
			@(posedge clk);
			{ty_hi, ty_lo} <= t[1:0];
			rt_hi <= t == 2;
			rt_lo <= t == 1;
			// The alternate rate port must win when written last
			hw(c == 1 ? FRPS_ADDR_CCR : FRPS_ADDR_STATUS, {6'h00, c[1:0]});
			pause(3);
			er = exp_rate(t == 3 ? 0 : t, c[1:0]);
			d = c == 3 || c == 0;
			chk({5'h0, rate}, {5'h0, er});
			chk({4'h0, fmok, dens, p1, p0}, {4'h0, er != FRPS_R1M && er != FRPS_R2M, d,
				t == 3 ? c[1] : c[0], t == 0 ? d : (t == 1 ? !d : (t == 2 ? c[1] : c[0]))});
		end
		hw(FRPS_ADDR_DOR, 8'h00);
		pause(1);
		chk({7'h0, crst}, 8'h01);
		hw(FRPS_ADDR_DOR, 8'h04);
		pause(2);
		chk({7'h0, crst}, 8'h00);
		chk({5'h0, rate}, {5'h0, FRPS_R1M});
		chk(shadow, 8'h03);
		hw(FRPS_ADDR_STATUS, 8'h42);
		pause(1);
		chk({7'h0, lpw}, 8'h01);
		hr(FRPS_ADDR_STATUS, 8'h00);
		chk({7'h0, lpw}, 8'h00);
		hw(FRPS_ADDR_STATUS, 8'h42);
		hr(FRPS_ADDR_DATA, 8'h00);
		chk({7'h0, lpw}, 8'h00);
		hr(16'h03f0, 8'h00);
		@(posedge clk);
		rdy <= 1'b1;
		toh <= 1'b1;
		pol <= 1'b1;
		hw(FRPS_ADDR_STATUS, 8'hc2);
		#1;
		chk({6'h0, crst, lpw}, 8'h02);
		hr(FRPS_ADDR_STATUS, 8'h00);
		// Soft reset is two cycles long, already released here
		chk({6'h0, crst, lpw}, 8'h00);
		pause(3);
		chk({7'h0, crst}, 8'h00);
		chk(shadow, 8'hc2);
		hr(FRPS_ADDR_STATUS, 8'hc0);
		start(1'b1, 8'h06, 1'b0);
		pause(2);
		hr(FRPS_ADDR_STATUS, 8'hf0);
		pause(6);
		hr(FRPS_ADDR_STATUS, 8'hc0);
		start(1'b0, 8'h28, 1'b1);
		pause(4);
		hr(FRPS_ADDR_STATUS, 8'hc2);
		pause(40);
		hr(FRPS_ADDR_STATUS, 8'hc0);
		start(1'b0, 8'h06, 1'b0);
		pause(3);
		hr(FRPS_ADDR_STATUS, 8'hc1);
		for (int h = 0; h < 2; h++) for (int c = 0; c < 8; c++) begin
			pc(h[0], c[2:0], 1'b0);
		end
		@(posedge clk);
		trk <= 8'h01;
		trk_ld <= 1'b1;
		@(posedge clk);
		trk_ld <= 1'b0;
		pc(1'b0, 3'h3, 1'b1);
		complete_run();
	end
endmodule : test_floppy_rate_write_delay_code_status

// ==== verilog/frps_pkg.sv ====
package frps_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Host addresses
	localparam logic [15:0] FRPS_ADDR_DOR = 16'h03f2;
	localparam logic [15:0] FRPS_ADDR_STATUS = 16'h03f4;
	localparam logic [15:0] FRPS_ADDR_DATA = 16'h03f5;
	localparam logic [15:0] FRPS_ADDR_CCR = 16'h03f7;

	////////////////////////////////////////////////////////////////////////////////
	// Rate select fields
	localparam int FRPS_RS_RATE_LO = 0;
	localparam int FRPS_RS_DLY_LO = 2;
	localparam int FRPS_RS_UNDEF = 5;
	localparam int FRPS_RS_LOWPWR = 6;
	localparam int FRPS_RS_SWRST = 7;
	localparam logic [7:0] FRPS_RS_RESET = 8'h02;
	localparam int FRPS_DOR_RESET_BIT = 2;
	localparam logic [7:0] FRPS_DOR_RESET = 8'h00;

	// Status fields
	localparam int FRPS_ST_DRVA = 0;
	localparam int FRPS_ST_DRVB = 1;
	localparam int FRPS_ST_BUSY = 4;
	localparam int FRPS_ST_POLL = 5;
	localparam int FRPS_ST_DIR = 6;
	localparam int FRPS_ST_RQM = 7;

	////////////////////////////////////////////////////////////////////////////////
	// Codes
	localparam logic [2:0] FRPS_DLY_DEFAULT = 3'h0;
	localparam logic [2:0] FRPS_DLY_NONE = 3'h7;
	localparam logic [1:0] FRPS_CODE_1M = 2'h3;
	localparam logic [1:0] FRPS_CODE_500K = 2'h0;
	localparam logic [1:0] FRPS_CODE_300K = 2'h1;
	localparam logic [1:0] FRPS_CODE_250K = 2'h2;
	localparam logic [1:0] FRPS_DRT_3MODE = 2'h1;
	localparam logic [1:0] FRPS_DRT_2MEG = 2'h2;
	localparam logic [7:0] FRPS_WRITE_DELAY_CODE_TRACK_RESET = 8'h00;

	typedef enum logic [2:0] {
		FRPS_R250K = 3'h0,
		FRPS_R300K = 3'h1,
		FRPS_R500K = 3'h3,
		FRPS_R1M = 3'h2,
		FRPS_R2M = 3'h6
	} frps_rate_t;

	////////////////////////////////////////////////////////////////////////////////
	// Times in picoseconds and derived cycle counts at 20 MHz
	localparam int FRPS_CLK_PS = 50000;
	localparam int FRPS_STEP_LO_PS = 41670;
	localparam int FRPS_STEP_HI_PS = 20800;
	localparam int FRPS_DEF_2M_PS = 20800;
	localparam int FRPS_DEF_1M_PS = 41670;
	localparam int FRPS_DEF_SLOW_PS = 125000;
	localparam int FRPS_SWRST_MIN_PS = 100000;
	localparam int FRPS_DLY_MAX_CYC = 6;

	// Delays are longest times: round down, never below one cycle
	function automatic logic [2:0] frps_dly_cyc(input int ps);
		int c;
		c = ps / FRPS_CLK_PS;
		if (c < 1) begin
			c = 1;
		end
		frps_dly_cyc = c[2:0];
	endfunction : frps_dly_cyc

	// Least time: round up
	localparam int FRPS_SWRST_CYC_I = (FRPS_SWRST_MIN_PS + FRPS_CLK_PS - 1) / FRPS_CLK_PS;
	localparam logic [2:0] FRPS_SWRST_CYC = FRPS_SWRST_CYC_I[2:0];

endpackage : frps_pkg

// ==== verilog/frps_top.sv ====
`timescale 1ns/100ps
module frps_top (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// Host register port
	input wire logic [15:0] HOST_ADDR,
	input wire logic [7:0] HOST_WDATA,
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	output logic [7:0] HOST_RDATA,
	// Command engine status
	input wire logic CMD_ACCEPTED,
	input wire logic RESULT_DONE,
	input wire logic LAST_BYTE_NO_RESULT,
	input wire logic EXEC_ACTIVE,
	input wire logic POLLED_MODE,
	input wire logic XFER_READY,
	input wire logic XFER_TO_HOST,
	input wire logic DRIVE_A_SEEKING,
	input wire logic DRIVE_B_SEEKING,
	// Drive configuration
	input wire logic DRIVE_RATE_TABLE_HI,
	input wire logic DRIVE_RATE_TABLE_LO,
	input wire logic DRIVE_TYPE_HI,
	input wire logic DRIVE_TYPE_LO,
	input wire logic [7:0] WRITE_DELAY_CODE_START_TRACK,
	input wire logic WRITE_DELAY_CODE_TRACK_LOAD,
	input wire logic [7:0] CURRENT_TRACK,
	// Write data path
	input wire logic WRITE_DATA_IN,
	output logic WRITE_DATA_OUT,
	// Controller control
	output logic CTRL_RESET,
	output logic LOW_POWER,
	output logic [7:0] RATE_SELECT_SHADOW,
	output frps_pkg::frps_rate_t DATA_RATE,
	output logic FM_HALF_RATE_OK,
	output logic DENSITY_SELECT,
	output logic DRIVE_DENSITY_PIN0,
	output logic DRIVE_DENSITY_PIN1
);
	import frps_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0] rate_select_r;
	logic [7:0] rate_select_nxt;
	logic [1:0] rate_code_r;
	logic [1:0] rate_code_nxt;
	logic [7:0] dor_r;
	logic [2:0] swrst_cnt_r;
	logic [2:0] swrst_cnt_nxt;
	logic low_power_r;
	logic low_power_nxt;
	logic cmd_busy_r;
	logic cmd_busy_nxt;
	logic [7:0] start_track_r;
	logic [7:0] rdata_nxt;
	logic ctrl_reset_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode
	wire sel_status = (HOST_ADDR == FRPS_ADDR_STATUS);
	wire sel_data = (HOST_ADDR == FRPS_ADDR_DATA);
	wire wr_rate = HOST_WR && sel_status;
	wire rd_status = HOST_RD && sel_status;
	wire wr_ccr = HOST_WR && (HOST_ADDR == FRPS_ADDR_CCR);
	wire wr_dor = HOST_WR && (HOST_ADDR == FRPS_ADDR_DOR);
	wire acc_wake = (HOST_WR || HOST_RD) && (sel_status || sel_data);
	wire sw_reset_req = wr_rate && HOST_WDATA[FRPS_RS_SWRST];
	wire sw_reset_act = (swrst_cnt_r != 3'h0);

	////////////////////////////////////////////////////////////////////////////////
	// Rate select register; bit 5 is stored as written, software keeps it zero
	always_comb begin
		rate_select_nxt = rate_select_r;
		if (wr_rate) begin
			rate_select_nxt = HOST_WDATA;
		end else begin
			rate_select_nxt[FRPS_RS_SWRST] = 1'b0;
		end
	end

	// Last writer of rate bits wins; soft reset leaves it alone
	always_comb begin
		rate_code_nxt = rate_code_r;
		if (wr_rate) begin
			rate_code_nxt = HOST_WDATA[FRPS_RS_RATE_LO +: 2];
		end else if (wr_ccr) begin
			rate_code_nxt = HOST_WDATA[FRPS_RS_RATE_LO +: 2];
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rate_select_r <= FRPS_RS_RESET;
			rate_code_r <= FRPS_RS_RESET[1:0];
			RATE_SELECT_SHADOW <= FRPS_RS_RESET;
		end else begin
			rate_select_r <= rate_select_nxt;
			rate_code_r <= rate_code_nxt;
			if (wr_rate) begin
				RATE_SELECT_SHADOW <= HOST_WDATA;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Controller reset: output-register bit low, or stretched soft pulse
	// The soft pulse is held long enough to meet the minimum reset width
	always_comb begin
		swrst_cnt_nxt = swrst_cnt_r;
		if (sw_reset_req) begin
			swrst_cnt_nxt = FRPS_SWRST_CYC;
		end else if (sw_reset_act) begin
			swrst_cnt_nxt = swrst_cnt_r - 3'h1;
		end
	end

	assign ctrl_reset_nxt = !dor_r[FRPS_DOR_RESET_BIT] || sw_reset_req || (swrst_cnt_nxt != 3'h0);

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			dor_r <= FRPS_DOR_RESET;
			swrst_cnt_r <= 3'h0;
			CTRL_RESET <= 1'b1;
		end else begin
			if (wr_dor) begin
				dor_r <= HOST_WDATA;
			end
			swrst_cnt_r <= swrst_cnt_nxt;
			CTRL_RESET <= ctrl_reset_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Manual low power; entering wins over the wake of the same status write
	always_comb begin
		low_power_nxt = low_power_r;
		if (sw_reset_req || acc_wake) begin
			low_power_nxt = 1'b0;
		end
		if (wr_rate && HOST_WDATA[FRPS_RS_LOWPWR] && !HOST_WDATA[FRPS_RS_SWRST]) begin
			low_power_nxt = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			low_power_r <= 1'b0;
		end else begin
			low_power_r <= low_power_nxt;
		end
	end

	assign LOW_POWER = low_power_r;

	////////////////////////////////////////////////////////////////////////////////
	// Command busy: set wins over a done clear in the same cycle; controller reset clears over both
	always_comb begin
		cmd_busy_nxt = cmd_busy_r;
		if (RESULT_DONE) begin
			cmd_busy_nxt = 1'b0;
		end
		if (LAST_BYTE_NO_RESULT) begin
			cmd_busy_nxt = 1'b0;
		end
		if (CMD_ACCEPTED) begin
			cmd_busy_nxt = 1'b1;
		end
		if (CTRL_RESET) begin
			cmd_busy_nxt = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cmd_busy_r <= 1'b0;
		end else begin
			cmd_busy_r <= cmd_busy_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main status, built from live inputs except the registered busy bit and the registered CTRL_RESET gate, so a read right after a transfer is valid
	wire host_transfer_request = XFER_READY && !CTRL_RESET;
	wire transfer_direction = host_transfer_request && XFER_TO_HOST;
	wire polled = POLLED_MODE && EXEC_ACTIVE;
	wire [7:0] status_word = {host_transfer_request, transfer_direction, polled, cmd_busy_r, 2'b00,
		DRIVE_B_SEEKING, DRIVE_A_SEEKING};

	// Only the status port is readable here; other reads return zero
	assign rdata_nxt = rd_status ? status_word : 8'h00;

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			HOST_RDATA <= 8'h00;
		end else begin
			HOST_RDATA <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data rate and density
	wire [1:0] drt = {DRIVE_RATE_TABLE_HI, DRIVE_RATE_TABLE_LO};
	wire [1:0] dtype = {DRIVE_TYPE_HI, DRIVE_TYPE_LO};
	wire is_300_slot = (rate_code_r == FRPS_CODE_300K);
	wire rate_2m = is_300_slot && (drt == FRPS_DRT_2MEG);
	wire rate_500_alt = is_300_slot && (drt == FRPS_DRT_3MODE);
	wire density = (rate_code_r == FRPS_CODE_1M) || (rate_code_r == FRPS_CODE_500K);
	frps_rate_t rate_nxt;

	always_comb begin
		rate_nxt = FRPS_R250K;
		unique case (rate_code_r)
			FRPS_CODE_1M: rate_nxt = FRPS_R1M;
			FRPS_CODE_500K: rate_nxt = FRPS_R500K;
			FRPS_CODE_300K: rate_nxt = rate_2m ? FRPS_R2M : (rate_500_alt ? FRPS_R500K : FRPS_R300K);
			FRPS_CODE_250K: rate_nxt = FRPS_R250K;
		endcase
	end

	// Pin pair per drive type
	logic pin1_nxt;
	logic pin0_nxt;

	always_comb begin
		pin1_nxt = rate_code_r[0];
		pin0_nxt = density;
		unique case (dtype)
			2'h0: begin
				pin1_nxt = rate_code_r[0];
				pin0_nxt = density;
			end
			2'h2: begin
				pin1_nxt = rate_code_r[0];
				pin0_nxt = rate_code_r[1];
			end
			2'h1: begin
				pin1_nxt = rate_code_r[0];
				pin0_nxt = !density;
			end
			2'h3: begin
				pin1_nxt = rate_code_r[1];
				pin0_nxt = rate_code_r[0];
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			DATA_RATE <= FRPS_R250K;
			FM_HALF_RATE_OK <= 1'b1;
			DENSITY_SELECT <= 1'b0;
			DRIVE_DENSITY_PIN0 <= 1'b0;
			DRIVE_DENSITY_PIN1 <= 1'b0;
		end else begin
			DATA_RATE <= rate_nxt;
			// FM runs at half the MFM rate; none exists at 1 or 2 Mbps
			FM_HALF_RATE_OK <= (rate_nxt != FRPS_R1M) && (rate_nxt != FRPS_R2M);
			DENSITY_SELECT <= density;
			DRIVE_DENSITY_PIN0 <= pin0_nxt;
			DRIVE_DENSITY_PIN1 <= pin1_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write precompensation. At 20 MHz sub-cycle steps round down to one cycle,
	// so fine steps collapse; a faster clock would resolve them.
	wire [2:0] dly_code = rate_select_r[FRPS_RS_DLY_LO +: 3];
	wire fast = (rate_nxt == FRPS_R2M);
	logic [2:0] tap_sel;
	logic [2:0] tap_def;
	logic [2:0] step_n;

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			start_track_r <= FRPS_WRITE_DELAY_CODE_TRACK_RESET;
		end else if (WRITE_DELAY_CODE_TRACK_LOAD) begin
			start_track_r <= WRITE_DELAY_CODE_START_TRACK;
		end
	end

	always_comb begin
		tap_def = frps_dly_cyc(FRPS_DEF_SLOW_PS);
		if (rate_nxt == FRPS_R2M) begin
			tap_def = frps_dly_cyc(FRPS_DEF_2M_PS);
		end else if (rate_nxt == FRPS_R1M) begin
			tap_def = frps_dly_cyc(FRPS_DEF_1M_PS);
		end
	end

	always_comb begin
		step_n = frps_dly_cyc(FRPS_STEP_LO_PS * int'(dly_code));
		if (fast) begin
			step_n = frps_dly_cyc(FRPS_STEP_HI_PS * int'(dly_code));
		end
		tap_sel = step_n;
		if (dly_code == FRPS_DLY_NONE) begin
			tap_sel = 3'h0;
		end else if (dly_code == FRPS_DLY_DEFAULT) begin
			tap_sel = tap_def;
		end
		if (CURRENT_TRACK < start_track_r) begin
			tap_sel = 3'h0;
		end
	end

	frps_wdly u_wdly (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.din(WRITE_DATA_IN),
		.tap(tap_sel),
		.dout(WRITE_DATA_OUT)
	);

endmodule : frps_top

// ==== verilog/frps_wdly.sv ====
`timescale 1ns/100ps
module frps_wdly (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data and tap
	input wire logic din,
	input wire logic [2:0] tap,
	output logic dout
);
	import frps_pkg::*;

	logic [FRPS_DLY_MAX_CYC-1:0] sr_r;
	logic sel;

	assign sel = (tap == 3'h0) ? din : sr_r[tap - 3'h1];

	genvar i;
	generate
		for (i = 0; i < FRPS_DLY_MAX_CYC; i++) begin : g_tap
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					sr_r[i] <= 1'b0;
				end else begin
					sr_r[i] <= (i == 0) ? din : sr_r[(i == 0) ? 0 : i - 1];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dout <= 1'b0;
		end else begin
			dout <= sel;
		end
	end

endmodule : frps_wdly
